/* hdl/reset_setup_pkg.sv */
package reset_setup_pkg;
  // Clocking
  localparam int unsigned CLOCK_HZ           = 10_000_000;
  localparam int unsigned REF_CLOCK_MHZ      = 100;
  // Function reset completion limit
  localparam int unsigned FUNC_RESET_LIMIT_MS     = 100;
  localparam int unsigned FUNC_RESET_LIMIT_CYCLES = FUNC_RESET_LIMIT_MS * (CLOCK_HZ / 1000);
  localparam int unsigned FUNC_TIMER_W            = 21;
  // Client reset release delay after all causes clear
  localparam int unsigned RELEASE_CYCLES     = 4;
  localparam int unsigned RELEASE_W          = 3;
  // Functions
  localparam int unsigned PF_NUM             = 4;
  localparam int unsigned VF_NUM             = 8;
  localparam int unsigned FUNC_IDX_W         = 3;
  // Channels
  localparam int unsigned CH_W               = 256;
  localparam int unsigned MSG_CODE_W         = 8;
  localparam int unsigned XCVR_NUM           = 8;
  // Status counters
  localparam int unsigned CREDIT_W           = 12;
  localparam int unsigned TAG_W              = 7;
  localparam logic [TAG_W-1:0] TAG_NUM       = 7'h40;
  // Link generation codes
  localparam logic [1:0] GEN1                = 2'h0;
  localparam logic [1:0] GEN2                = 2'h1;
  localparam logic [1:0] GEN3                = 2'h2;
  // Lane count codes
  localparam logic [1:0] LANES_X1            = 2'h0;
  localparam logic [1:0] LANES_X2            = 2'h1;
  localparam logic [1:0] LANES_X4            = 2'h2;
  localparam logic [1:0] LANES_X8            = 2'h3;
  // Channel width codes
  localparam logic [1:0] WIDTH_64            = 2'h0;
  localparam logic [1:0] WIDTH_128           = 2'h1;
  localparam logic [1:0] WIDTH_256           = 2'h2;
  // Client clock codes
  localparam logic [1:0] CLK_62M5            = 2'h0;
  localparam logic [1:0] CLK_125M            = 2'h1;
  localparam logic [1:0] CLK_250M            = 2'h2;
  // Link sequencing states
  typedef enum logic [1:0] {
    LINK_HARD_RESET,
    LINK_TRAIN,
    LINK_UP
  } link_state_t;
endpackage

/* hdl/chan_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module chan_stage #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic         flush_i,
  // Upstream side
  input  wire logic         in_valid_i,
  input  wire logic         in_drop_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Downstream side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic         valid_q;
  logic [W-1:0] data_q;
  wire          take_w = in_valid_i && in_ready_o;
  wire          load_w = take_w && !in_drop_i;

  // Dropped beats are consumed without a trace downstream
  assign in_ready_o  = !flush_i && (!valid_q || out_ready_i);
  assign out_valid_o = valid_q;
  assign out_data_o  = data_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
    end else if (flush_i) begin
      valid_q <= 1'b0;
    end else if (take_w || out_ready_i) begin
      valid_q <= load_w;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      data_q <= '0;
    end else if (load_w) begin
      data_q <= in_data_i;
    end
  end
endmodule
`default_nettype wire

/* hdl/reset_setup.sv */
// How it works
// - Fundamental reset hard-resets core and transceivers
// - After release, train link, then run
// - In-band hot reset raises hot reset flag
// - Function reset sets its in-progress bit
// - Traffic for resetting function dropped silently
// - Client reset on fundamental or lost lock
// - Client reset released synchronously, all causes clear
// - Four client channels, two each direction
// - Target requests accepted while responses pending
// - All channels share one configured width
// - Selectable clock and width per lane count
// - 2.5 GT/s allowed width and clock pairs
// - 5.0 GT/s allowed width and clock pairs
// - 8.0 GT/s allowed width and clock pairs
// - Report available transmit credit
// - Report free non-posted tags
// - Messages reported on own interface
`timescale 1ns/1ps
`default_nettype none
module reset_setup
  import reset_setup_pkg::*;
#(
  parameter int unsigned FUNC_LIMIT = FUNC_RESET_LIMIT_CYCLES
) (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // Fundamental reset and lock status
  input  wire logic                  fund_reset_n_i,
  input  wire logic                  core_pll_locked_i,
  input  wire logic [XCVR_NUM-1:0]   xcvr_pll_locked_i,
  output logic                       xcvr_reset_o,
  output logic                       user_reset_o,
  // Link sequencing
  output logic                       link_train_o,
  input  wire logic                  link_up_i,
  input  wire logic                  hot_reset_link_i,
  output logic                       hot_reset_o,
  // Configuration
  input  wire logic [1:0]            cfg_gen_i,
  input  wire logic [1:0]            cfg_lanes_i,
  input  wire logic [1:0]            cfg_width_i,
  input  wire logic [1:0]            cfg_clk_i,
  output logic                       cfg_valid_o,
  output logic [1:0]                 chan_width_o,
  // Function resets
  input  wire logic                  func_reset_req_i,
  input  wire logic                  func_reset_vf_i,
  input  wire logic [FUNC_IDX_W-1:0] func_reset_idx_i,
  output logic [PF_NUM-1:0]          pf_func_reset_active_o,
  output logic [VF_NUM-1:0]          vf_func_reset_active_o,
  input  wire logic [PF_NUM-1:0]     pf_func_reset_complete_i,
  input  wire logic [VF_NUM-1:0]     vf_func_reset_complete_i,
  output logic                       func_reset_late_o,
  // Error reporting
  input  wire logic                  err_detect_i,
  input  wire logic                  err_vf_i,
  input  wire logic [FUNC_IDX_W-1:0] err_idx_i,
  output logic                       err_report_o,
  // Target request channel, link to user
  input  wire logic                  link_treq_valid_i,
  output logic                       link_treq_ready_o,
  input  wire logic [CH_W-1:0]       link_treq_data_i,
  input  wire logic                  link_treq_vf_i,
  input  wire logic [FUNC_IDX_W-1:0] link_treq_idx_i,
  input  wire logic                  link_treq_msg_i,
  input  wire logic [MSG_CODE_W-1:0] link_treq_msg_code_i,
  output logic                       target_request_channel_valid_o,
  input  wire logic                  target_request_channel_ready_i,
  output logic [CH_W-1:0]            target_request_channel_data_o,
  // Received message interface
  output logic                       msg_valid_o,
  output logic [MSG_CODE_W-1:0]      msg_code_o,
  // Target response channel, user to link
  input  wire logic                  target_response_channel_valid_i,
  output logic                       target_response_channel_ready_o,
  input  wire logic [CH_W-1:0]       target_response_channel_data_i,
  output logic                       link_tresp_valid_o,
  input  wire logic                  link_tresp_ready_i,
  output logic [CH_W-1:0]            link_tresp_data_o,
  // Initiator request channel, user to link
  input  wire logic                  initiator_request_channel_valid_i,
  output logic                       initiator_request_channel_ready_o,
  input  wire logic [CH_W-1:0]       initiator_request_channel_data_i,
  input  wire logic                  initiator_request_channel_np_i,
  output logic                       link_ireq_valid_o,
  input  wire logic                  link_ireq_ready_i,
  output logic [CH_W-1:0]            link_ireq_data_o,
  // Initiator response channel, link to user
  input  wire logic                  link_iresp_valid_i,
  output logic                       link_iresp_ready_o,
  input  wire logic [CH_W-1:0]       link_iresp_data_i,
  input  wire logic                  link_iresp_vf_i,
  input  wire logic [FUNC_IDX_W-1:0] link_iresp_idx_i,
  input  wire logic                  link_iresp_last_i,
  output logic                       initiator_response_channel_valid_o,
  input  wire logic                  initiator_response_channel_ready_i,
  output logic [CH_W-1:0]            initiator_response_channel_data_o,
  // Flow control and tag status
  input  wire logic [CREDIT_W-1:0]   fc_limit_i,
  input  wire logic                  fc_return_i,
  input  wire logic [CREDIT_W-1:0]   fc_return_amt_i,
  output logic [CREDIT_W-1:0]        fc_credit_o,
  output logic [TAG_W-1:0]           tags_free_o
);
  ////////////////////////////////////////////////////////////////////////
  // Reset causes and link sequencing
  link_state_t           state_q;
  link_state_t           state_d;
  logic                  hot_q;
  logic                  ureset_q;
  logic [RELEASE_W-1:0]  rel_cnt_q;

  // Reset cause collection
  wire fund_w   = !fund_reset_n_i;
  wire cause_w  = fund_w || !core_pll_locked_i || !(&xcvr_pll_locked_i);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LINK_HARD_RESET: if (!fund_w) state_d = LINK_TRAIN;
      LINK_TRAIN:      if (link_up_i) state_d = LINK_UP;
      LINK_UP:         if (!link_up_i) state_d = LINK_TRAIN;
    endcase
    if (fund_w) state_d = LINK_HARD_RESET;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= LINK_HARD_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign xcvr_reset_o = (state_q == LINK_HARD_RESET);
  assign link_train_o = (state_q == LINK_TRAIN);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hot_q <= 1'b0;
    end else begin
      hot_q <= hot_reset_link_i && !fund_w;
    end
  end
  assign hot_reset_o = hot_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ureset_q  <= 1'b1;
      rel_cnt_q <= '0;
    end else if (cause_w) begin
      ureset_q  <= 1'b1;
      rel_cnt_q <= '0;
    end else if (rel_cnt_q != RELEASE_W'(RELEASE_CYCLES - 1)) begin
      rel_cnt_q <= rel_cnt_q + 1'b1;
    end else begin
      ureset_q  <= 1'b0;
    end
  end
  assign user_reset_o = ureset_q;

  ////////////////////////////////////////////////////////////////////////
  // Configuration check

  function automatic logic cfg_ok(input logic [1:0] g, input logic [1:0] l,
                                  input logic [1:0] w, input logic [1:0] c);
    logic ok;
    ok = 1'b0;
    unique case (g)
      GEN1: unique case (l)
        LANES_X1, LANES_X2: ok = (w == WIDTH_64) && (c != 2'h3);
        LANES_X4: ok = (w == WIDTH_64) && (c == CLK_125M || c == CLK_250M);
        LANES_X8: ok = (w == WIDTH_64 && c == CLK_250M) || (w == WIDTH_128 && c == CLK_125M);
      endcase
      GEN2: unique case (l)
        LANES_X1: ok = (w == WIDTH_64) && (c != 2'h3);
        LANES_X2: ok = (w == WIDTH_64) && (c == CLK_125M || c == CLK_250M);
        LANES_X4: ok = (w == WIDTH_64 && c == CLK_250M) || (w == WIDTH_128 && c == CLK_125M);
        LANES_X8: ok = (w == WIDTH_128 && c == CLK_250M) || (w == WIDTH_256 && c == CLK_125M);
      endcase
      GEN3: unique case (l)
        LANES_X1: ok = (w == WIDTH_64) && (c == CLK_125M || c == CLK_250M);
        LANES_X2: ok = (w == WIDTH_64 && c == CLK_250M) || (w == WIDTH_128 && c == CLK_125M);
        LANES_X4: ok = (w == WIDTH_128 && c == CLK_250M) || (w == WIDTH_256 && c == CLK_125M);
        LANES_X8: ok = (w == WIDTH_256) && (c == CLK_250M);
      endcase
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  assign cfg_valid_o  = cfg_ok(cfg_gen_i, cfg_lanes_i, cfg_width_i, cfg_clk_i);
  assign chan_width_o = cfg_width_i;

  ////////////////////////////////////////////////////////////////////////
  // Function resets
  logic [PF_NUM-1:0] pf_act_q;
  logic [VF_NUM-1:0] vf_act_q;
  logic [PF_NUM+VF_NUM-1:0] late_w;

  genvar gi;
  generate
    for (gi = 0; gi < PF_NUM + VF_NUM; gi++) begin : g_func
      localparam bit IS_VF = (gi >= PF_NUM);
      localparam int unsigned IDX = IS_VF ? gi - PF_NUM : gi;
      logic                    act_q;
      logic                    late_q;
      logic [FUNC_TIMER_W-1:0] timer_q;
      wire set_w  = func_reset_req_i && (func_reset_vf_i == IS_VF) &&
                    (func_reset_idx_i == FUNC_IDX_W'(IDX));
      wire done_w = IS_VF ? vf_func_reset_complete_i[IDX] : pf_func_reset_complete_i[IDX];
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          act_q <= 1'b0;
        end else if (ureset_q) begin
          act_q <= 1'b0;
        end else if (set_w) begin
          act_q <= 1'b1;
        end else if (done_w) begin
          act_q <= 1'b0;
        end
      end
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          timer_q <= '0;
          late_q  <= 1'b0;
        end else if (!act_q || set_w) begin
          timer_q <= '0;
          late_q  <= 1'b0;
        end else if (timer_q != FUNC_TIMER_W'(FUNC_LIMIT)) begin
          timer_q <= timer_q + 1'b1;
        end else begin
          late_q  <= 1'b1;
        end
      end
      assign late_w[gi] = late_q;
      if (IS_VF) begin : g_vf
        assign vf_act_q[IDX] = act_q;
      end else begin : g_pf
        assign pf_act_q[IDX] = act_q;
      end
    end
  endgenerate

  assign pf_func_reset_active_o = pf_act_q;
  assign vf_func_reset_active_o = vf_act_q;
  assign func_reset_late_o      = |late_w;

  // Lookup of a function's reset state
  wire treq_hold_w  = link_treq_vf_i ? vf_act_q[link_treq_idx_i]
                                     : pf_act_q[link_treq_idx_i[1:0]];
  wire iresp_hold_w = link_iresp_vf_i ? vf_act_q[link_iresp_idx_i]
                                      : pf_act_q[link_iresp_idx_i[1:0]];
  wire err_hold_w   = err_vf_i ? vf_act_q[err_idx_i] : pf_act_q[err_idx_i[1:0]];

  assign err_report_o = err_detect_i && !err_hold_w;

  ////////////////////////////////////////////////////////////////////////
  // Client channels
  logic                  msg_q;
  logic [MSG_CODE_W-1:0] msg_code_q;
  logic                  ireq_take_w;
  logic                  iresp_take_w;

  wire treq_drop_w = treq_hold_w || link_treq_msg_i;

  chan_stage #(.W(CH_W)) u_treq (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .flush_i     (ureset_q),
    .in_valid_i  (link_treq_valid_i),
    .in_drop_i   (treq_drop_w),
    .in_data_i   (link_treq_data_i),
    .in_ready_o  (link_treq_ready_o),
    .out_valid_o (target_request_channel_valid_o),
    .out_ready_i (target_request_channel_ready_i),
    .out_data_o  (target_request_channel_data_o)
  );

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      msg_q      <= 1'b0;
      msg_code_q <= '0;
    end else begin
      msg_q <= link_treq_valid_i && link_treq_ready_o && link_treq_msg_i && !treq_hold_w;
      if (link_treq_valid_i && link_treq_msg_i) begin
        msg_code_q <= link_treq_msg_code_i;
      end
    end
  end
  assign msg_valid_o = msg_q;
  assign msg_code_o  = msg_code_q;

  chan_stage #(.W(CH_W)) u_tresp (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .flush_i     (ureset_q),
    .in_valid_i  (target_response_channel_valid_i),
    .in_drop_i   (1'b0),
    .in_data_i   (target_response_channel_data_i),
    .in_ready_o  (target_response_channel_ready_o),
    .out_valid_o (link_tresp_valid_o),
    .out_ready_i (link_tresp_ready_i),
    .out_data_o  (link_tresp_data_o)
  );

  // Requests stall on no credit; non-posted requests also stall on no tag
  logic [CREDIT_W-1:0] credit_q;
  logic [TAG_W-1:0]    tags_q;
  logic                ireq_rdy_w;
  wire ireq_ok_w = (credit_q != '0) && (!initiator_request_channel_np_i || tags_q != '0);

  chan_stage #(.W(CH_W)) u_ireq (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .flush_i     (ureset_q),
    .in_valid_i  (initiator_request_channel_valid_i && ireq_ok_w),
    .in_drop_i   (1'b0),
    .in_data_i   (initiator_request_channel_data_i),
    .in_ready_o  (ireq_rdy_w),
    .out_valid_o (link_ireq_valid_o),
    .out_ready_i (link_ireq_ready_i),
    .out_data_o  (link_ireq_data_o)
  );
  assign initiator_request_channel_ready_o = ireq_rdy_w && ireq_ok_w;
  assign ireq_take_w = initiator_request_channel_valid_i && initiator_request_channel_ready_o;

  chan_stage #(.W(CH_W)) u_iresp (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .flush_i     (ureset_q),
    .in_valid_i  (link_iresp_valid_i),
    .in_drop_i   (iresp_hold_w),
    .in_data_i   (link_iresp_data_i),
    .in_ready_o  (link_iresp_ready_o),
    .out_valid_o (initiator_response_channel_valid_o),
    .out_ready_i (initiator_response_channel_ready_i),
    .out_data_o  (initiator_response_channel_data_o)
  );
  assign iresp_take_w = link_iresp_valid_i && link_iresp_ready_o && link_iresp_last_i;

  ////////////////////////////////////////////////////////////////////////
  // Status interfaces
  wire link_rise_w = (state_q == LINK_TRAIN) && link_up_i;
  wire tag_dec_w   = ireq_take_w && initiator_request_channel_np_i;
  // Saturates so a stray release cannot overflow the count
  wire tag_inc_w   = iresp_take_w && (tags_q != TAG_NUM);
  wire [CREDIT_W-1:0] credit_add_w = fc_return_i ? fc_return_amt_i : '0;
  wire [CREDIT_W-1:0] credit_sub_w = {{(CREDIT_W-1){1'b0}}, ireq_take_w};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      credit_q <= '0;
    end else if (ureset_q || state_q != LINK_UP && !link_rise_w) begin
      credit_q <= '0;
    end else if (link_rise_w) begin
      credit_q <= fc_limit_i;
    end else begin
      credit_q <= credit_q + credit_add_w - credit_sub_w;
    end
  end
  assign fc_credit_o = credit_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tags_q <= TAG_NUM;
    end else if (ureset_q) begin
      tags_q <= TAG_NUM;
    end else if (tag_dec_w && !tag_inc_w) begin
      tags_q <= tags_q - 1'b1;
    end else if (tag_inc_w && !tag_dec_w) begin
      tags_q <= tags_q + 1'b1;
    end
  end
  assign tags_free_o = tags_q;
endmodule
`default_nettype wire

/* testbench/reset_setup_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_setup_monitor
  import reset_setup_pkg::*;
(
  // Clock and reset
  input wire logic                  clock_i,
  input wire logic                  rst_i,
  // Causes and requests
  input wire logic                  fund_reset_n_i,
  input wire logic                  core_pll_locked_i,
  input wire logic [XCVR_NUM-1:0]   xcvr_pll_locked_i,
  input wire logic                  hot_reset_link_i,
  input wire logic                  func_reset_req_i,
  input wire logic                  func_reset_vf_i,
  input wire logic [FUNC_IDX_W-1:0] func_reset_idx_i,
  input wire logic                  err_detect_i,
  input wire logic                  err_vf_i,
  input wire logic [FUNC_IDX_W-1:0] err_idx_i,
  input wire logic                  link_treq_valid_i,
  input wire logic                  link_treq_msg_i,
  // Watched outputs
  input wire logic                  xcvr_reset_o,
  input wire logic                  user_reset_o,
  input wire logic                  link_train_o,
  input wire logic                  hot_reset_o,
  input wire logic [VF_NUM-1:0]     vf_func_reset_active_o,
  input wire logic                  err_report_o,
  input wire logic                  link_treq_ready_o,
  input wire logic                  msg_valid_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic ok;
  assign ok = fund_reset_n_i & core_pll_locked_i & (&xcvr_pll_locked_i);
  ////////////////////////////////////////////////////////////
  property p_hard; !fund_reset_n_i |=> xcvr_reset_o; endproperty
  a_hard: assert property (p_hard) else $error("no hard reset");
  property p_train; xcvr_reset_o && fund_reset_n_i |=> link_train_o; endproperty
  a_train: assert property (p_train) else $error("no training");
  property p_cause; !ok |=> user_reset_o; endproperty
  a_cause: assert property (p_cause) else $error("client reset missing");
  // Clear at the first and fourth edge before release
  property p_rel; $fell(user_reset_o) |-> $past(ok) && $past(ok, 4); endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_hot; hot_reset_link_i && fund_reset_n_i |=> hot_reset_o; endproperty
  a_hot: assert property (p_hot) else $error("hot reset missing");
  property p_flr;
    func_reset_req_i && func_reset_vf_i && !user_reset_o && ok |=> vf_func_reset_active_o[$past(func_reset_idx_i)];
  endproperty
  a_flr: assert property (p_flr) else $error("reset bit missing");
  property p_err; err_report_o |-> err_detect_i && !(err_vf_i && vf_func_reset_active_o[err_idx_i]); endproperty
  a_err: assert property (p_err) else $error("error not dropped");
  property p_msg; msg_valid_o |-> $past(link_treq_valid_i && link_treq_ready_o && link_treq_msg_i); endproperty
  a_msg: assert property (p_msg) else $error("stray message");
  c_rel: cover property ($fell(user_reset_o));
  c_msg: cover property (msg_valid_o);
  c_hot: cover property (hot_reset_o);
endmodule
bind reset_setup reset_setup_monitor u_mon (.*);
`default_nettype wire

/* testbench/func_reset_responder.sv */
`timescale 1ns/1ps
`default_nettype none
module func_reset_responder
  import reset_setup_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  // Cycles from reset start to done
  input  wire logic [7:0]        wait_i,
  // Function reset handshake
  input  wire logic [PF_NUM-1:0] pf_active_i,
  input  wire logic [VF_NUM-1:0] vf_active_i,
  output logic      [PF_NUM-1:0] pf_done_o,
  output logic      [VF_NUM-1:0] vf_done_o
);
  logic [7:0] cnt_q;
  logic       busy;
  assign busy = |{pf_active_i, vf_active_i};
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= busy ? cnt_q + 8'h01 : 8'h00;
    end
  end
  assign pf_done_o = (cnt_q == wait_i) ? pf_active_i : '0;
  assign vf_done_o = (cnt_q == wait_i) ? vf_active_i : '0;
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin n_compared++; if ((a)!==(e)) begin bad_count++; $display("wrong value %s %0h %0h",n,e,a); end end
module testbench;
  import reset_setup_pkg::*;
  logic clock_i='0, rst_i='1, fund_reset_n_i='0, core_pll_locked_i='1, link_up_i='0, hot_reset_link_i='0;
  logic func_reset_req_i='0, func_reset_vf_i='0, err_detect_i='0, err_vf_i='0, fc_return_i='0, link_treq_vf_i='0;
  logic link_treq_valid_i='0, link_treq_msg_i='0, target_request_channel_ready_i='1, link_tresp_ready_i='0;
  logic target_response_channel_valid_i='0, initiator_request_channel_valid_i='0, initiator_request_channel_np_i='0;
  logic link_ireq_ready_i='1, link_iresp_valid_i='0, link_iresp_vf_i='0, link_iresp_last_i='0;
  logic initiator_response_channel_ready_i='1, xcvr_reset_o, user_reset_o, link_train_o, hot_reset_o;
  logic cfg_valid_o, func_reset_late_o, err_report_o, link_treq_ready_o, target_request_channel_valid_o;
  logic msg_valid_o, target_response_channel_ready_o, link_tresp_valid_o, initiator_request_channel_ready_o;
  logic link_ireq_valid_o, link_iresp_ready_o, initiator_response_channel_valid_o;
  logic [XCVR_NUM-1:0] xcvr_pll_locked_i='1;
  logic [7:0] link_treq_msg_code_i='0, msg_code_o, wait_cyc=8'h03;
  logic [1:0] cfg_gen_i='0, cfg_lanes_i='0, cfg_width_i='0, cfg_clk_i='0, chan_width_o;
  logic [FUNC_IDX_W-1:0] func_reset_idx_i='0, err_idx_i='0, link_treq_idx_i='0, link_iresp_idx_i='0;
  logic [CH_W-1:0] link_treq_data_i='0, target_response_channel_data_i='0, initiator_request_channel_data_i='0;
  logic [CH_W-1:0] link_iresp_data_i='0, target_request_channel_data_o, link_tresp_data_o, link_ireq_data_o;
  logic [CH_W-1:0] initiator_response_channel_data_o;
  logic [CREDIT_W-1:0] fc_limit_i=12'h005, fc_return_amt_i='0, fc_credit_o;
  logic [TAG_W-1:0] tags_free_o;
  logic [PF_NUM-1:0] pf_func_reset_active_o, pf_func_reset_complete_i;
  logic [VF_NUM-1:0] vf_func_reset_active_o, vf_func_reset_complete_i;
  int bad_count=0, n_compared=0;
  // Rows: gen, lanes, width, clock, legal
  logic [8:0] rows [10] = '{9'h06b, 9'h040, 9'h0f3, 9'h0a0, 9'h175, 9'h100, 9'h12b, 9'h001, 9'h180, 9'h0cb};
  ////////////////////////////////////////////////////////////
  reset_setup #(.FUNC_LIMIT(20)) dut (.*);
  func_reset_responder app (.clock_i, .rst_i, .wait_i(wait_cyc), .pf_active_i(pf_func_reset_active_o),
    .vf_active_i(vf_func_reset_active_o), .pf_done_o(pf_func_reset_complete_i), .vf_done_o(vf_func_reset_complete_i));
  always #50 clock_i = ~clock_i;
  // Inputs move 10 ns after the edge, clear of sampling
  task step(input int n); repeat (n) @(posedge clock_i); #10; endtask
  task done(input string s); $display("end %s", s); endtask
  task print_verdict;
    $display("compared %0d wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock_i);
    bad_count++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    step(2);
    `CHK("ures", 1'b1, user_reset_o)
    `CHK("tags", TAG_NUM, tags_free_o)
    `CHK("xrst", 1'b1, xcvr_reset_o)
    rst_i = 0; fund_reset_n_i = 1; step(1);
    `CHK("train", 1'b1, link_train_o)
    step(2); `CHK("ures", 1'b1, user_reset_o)
    step(1); `CHK("ures", 1'b0, user_reset_o)
    link_up_i = 1; step(1); `CHK("credit", 12'h005, fc_credit_o)
    done("bring-up");
    foreach (rows[i]) begin
      {cfg_gen_i, cfg_lanes_i, cfg_width_i, cfg_clk_i} = rows[i][8:1];
      #1;
      `CHK("valid", rows[i][0], cfg_valid_o)
      `CHK("width", rows[i][4:3], chan_width_o)
    end
    done("table");
    target_response_channel_valid_i = 1; target_response_channel_data_i = 256'h7;
    link_treq_valid_i = 1; link_treq_data_i = 256'h1; step(1);
    target_response_channel_valid_i = 0;
    `CHK("treq", 256'h1, target_request_channel_data_o)
    `CHK("tresp", 1'b1, link_tresp_valid_o)
    link_treq_data_i = 256'h2; step(1);
    `CHK("treq", 256'h2, target_request_channel_data_o)
    `CHK("trdy", 1'b1, link_treq_ready_o)
    link_treq_msg_i = 1; link_treq_msg_code_i = 8'h5a; step(1);
    link_treq_valid_i = 0; link_treq_msg_i = 0;
    `CHK("msg", 1'b1, msg_valid_o)
    `CHK("code", 8'h5a, msg_code_o)
    `CHK("fwd", 1'b0, target_request_channel_valid_o)
    step(1); `CHK("msg", 1'b0, msg_valid_o)
    `CHK("tresp", 1'b1, link_tresp_valid_o)
    link_tresp_ready_i = 1; step(1); `CHK("tresp", 1'b0, link_tresp_valid_o)
    done("channels");
    initiator_request_channel_valid_i = 1; initiator_request_channel_np_i = 1; step(1);
    initiator_request_channel_valid_i = 0;
    `CHK("credit", 12'h004, fc_credit_o)
    `CHK("tags", 7'h3f, tags_free_o)
    `CHK("ireq", 1'b1, link_ireq_valid_o)
    link_iresp_valid_i = 1; link_iresp_last_i = 1; fc_return_i = 1; fc_return_amt_i = 12'h003; step(1);
    link_iresp_valid_i = 0; fc_return_i = 0;
    `CHK("tags", TAG_NUM, tags_free_o)
    `CHK("credit", 12'h007, fc_credit_o)
    hot_reset_link_i = 1; step(1); `CHK("hot", 1'b1, hot_reset_o)
    hot_reset_link_i = 0; step(1); `CHK("hot", 1'b0, hot_reset_o)
    done("status");
    func_reset_req_i = 1; func_reset_vf_i = 1; func_reset_idx_i = 3'h5; step(1); func_reset_req_i = 0;
    `CHK("vfact", 8'h20, vf_func_reset_active_o)
    err_detect_i = 1; err_vf_i = 1; err_idx_i = 3'h5; #1;
    `CHK("err", 1'b0, err_report_o)
    err_idx_i = 3'h4; #1;
    `CHK("err", 1'b1, err_report_o)
    err_detect_i = 0; step(6); `CHK("vfact", 8'h00, vf_func_reset_active_o)
    wait_cyc = 8'h28; func_reset_req_i = 1; func_reset_vf_i = 0; func_reset_idx_i = 3'h2; step(1);
    func_reset_req_i = 0; step(24);
    `CHK("late", 1'b1, func_reset_late_o)
    `CHK("pfact", 4'h4, pf_func_reset_active_o)
    step(20); `CHK("late", 1'b0, func_reset_late_o)
    `CHK("pfact", 4'h0, pf_func_reset_active_o)
    done("function");
    core_pll_locked_i = 0; step(2); `CHK("ures", 1'b1, user_reset_o)
    core_pll_locked_i = 1; xcvr_pll_locked_i[3] = 0; step(5); `CHK("ures", 1'b1, user_reset_o)
    xcvr_pll_locked_i = '1; step(5); `CHK("ures", 1'b0, user_reset_o)
    link_up_i = 0; fund_reset_n_i = 0; step(2);
    `CHK("xrst", 1'b1, xcvr_reset_o)
    `CHK("ures", 1'b1, user_reset_o)
    fund_reset_n_i = 1; step(1); `CHK("train", 1'b1, link_train_o)
    done("resets");
    print_verdict;
  end
endmodule
`default_nettype wire
